// ==== common/sysctl_consts.svh ====
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH
// register offsets
`define RA_PART_LO 8'h00
`define RA_PART_HI 8'h01
`define RA_REV 8'h02
`define RA_SYSMAIN 8'h03
`define RA_CLKCFG 8'h04
`define RA_IRQCFG 8'h06
`define RA_FLAGS 8'h08
`define RA_MASK 8'h09
`define RA_PINF_LO 8'h0a
`define RA_PINF_HI 8'h0b
`define RA_PINE_LO 8'h0c
`define RA_PINE_HI 8'h0d
`define RA_PWMF 8'h0e
`define RA_PWME 8'h0f
// field positions
`define SYS_STANDBY 0
`define SYS_SOFTRST 1
`define SYS_SLEEP 3
`define SYS_SPEED 4
`define CLK_CS_OFF 0
`define CLK_PWM_OFF 1
`define CLK_GPIO_OFF 2
`define IRQ_MASTER 0
`define IRQ_TYPE 1
`define IRQ_POL 2
`define FLAG_RESUME 5
// reset values
`define RST_SYSMAIN 8'h00
`define RST_CLKCFG 8'hfe
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
// timing
`define CLK_HZ 100000000
`define CLK_PERIOD_NS 10
`define ENGINE_HZ 2000000
`define ENG_DIV (`CLK_HZ / `ENGINE_HZ)
`define SDIV_BASE 13'h0040
`define SDIV_FIRST 3'h3
`define PWM_HZ_MIN 16000
`define PWM_INC_BASE ((`PWM_HZ_MIN * 64'd16777216) / `CLK_HZ)
`define IRQ_PULSE_NS 1000
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== common/sysctl_pkg.sv ====
package sysctl_pkg;
   // event inputs from the surrounding modules, one-cycle pulses
   typedef struct packed {
      logic [15:0] pin_change;
      logic [7:0] pwm_done;
      logic sleep_resume;
      logic drift_alarm;
      logic cal_done;
      logic touch;
      logic ratio_unit_two_event;
      logic ratio_unit_one_event;
   } event_in_t;
   // clock and power controls toward the surrounding modules
   typedef struct packed {
      logic engine_tick;
      logic sensor_tick;
      logic pwm_tick;
      logic gpio_clk_en;
      logic pwm_clk_en;
      logic sense_clk_en;
      logic sleep_en;
      logic engine_speed_sel;
      logic deep_standby;
      logic soft_reset;
   } clock_ctl_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RECV = 5'b00010,
      ST_ACK = 5'b00100,
      ST_SEND = 5'b01000,
      ST_RACK = 5'b10000
   } bus_state_t;
endpackage

// ==== core/system_control_and_interrupts.sv ====
`timescale 1ns/10ps
`include "sysctl_consts.svh"
// Notes on behaviour
// - speed select zero means 2 MHz engine; one is reserved, engine stays 2 MHz.
// - control bit 3 enables touch sensor sleep mode.
// - writing one to control bit 1 soft-resets the device.
// - writing one to control bit 0 forces deep standby.
// - deep standby bit reads zero; the bus access wakes the device.
// - sensor divider codes 011..111 give 64..1024; lower codes reserved.
// - sensor clock is 2 MHz over 4.5 spread factor times divisor.
// - PWM clock field picks 16, 32, 64 or 128 kHz.
// - clock bits 2 and 1 stop GPIO and PWM module clocks.
// - clock bit 0 stops the sensing module clock.
// - polarity bit: zero active low, one active high.
// - type bit: zero level, one edge signalling.
// - master enable gates the interrupt output.
// - eight sticky flags, set by events, cleared by writing one.
// - PWM flag on sequence done, GPIO flag on pin activity.
// - resume flag set on leaving sleep or standby.
// - drift flag on stuck calibration or tuning out of range.
// - calibration flag when host-started calibration completes.
// - touch flag on touch; ratio flags on touch or data ready.
// - source mask shares flag layout; one enables a source.
// - per-pin change flags set on change, cleared by writing one.
// - per-channel PWM done flags set on completion, write one clears.
// - per-channel PWM enable lets its completion raise the interrupt.
module system_control_and_interrupts #(
   parameter logic [6:0] BUS_ADDR = 7'h2a, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h5a5a, // arbitrary value
   parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
   parameter int PULSE_CYC = `IRQ_PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input sysctl_pkg::event_in_t events,
   output sysctl_pkg::clock_ctl_t clk_ctl,
   output logic irq_out
);
   import sysctl_pkg::*;
   // elaboration checks
   if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_pulse
      $error("PULSE_CYC out of range");
   end
   logic [1:0] sysmain_reg;
   logic deep_standby_reg;
   logic soft_rst_reg;
   logic [7:0] clkcfg_reg;
   logic [2:0] irqcfg_reg;
   logic [7:0] flags_reg;
   logic [7:0] mask_reg;
   logic [15:0] pin_flags_reg;
   logic [15:0] pin_en_reg;
   logic [7:0] pwm_flags_reg;
   logic [7:0] pwm_en_reg;
   // serial bus slave state
   bus_state_t st_reg;
   logic scl_q, sda_q;
   logic [3:0] bits_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic first_reg, have_ptr_reg, rw_reg, nack_reg, oe_reg;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic byte_done, addr_hit, wr_pulse;
   logic [7:0] rd_byte;
   // bus line edges; inputs are synchronous to clk
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_det = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_det = scl_in & scl_q & ~sda_q & sda_in;
   assign byte_done = (st_reg == ST_RECV) && scl_fall && (bits_reg == 4'h8);
   assign addr_hit = byte_done && first_reg && (shift_reg[7:1] == BUS_ADDR);
   assign wr_pulse = byte_done && !first_reg && have_ptr_reg;
   assign sda_out = 1'b0; // open drain, only pulls low
   assign sda_oe = oe_reg;
   // read selection; standby and soft reset bits read zero
   assign rd_byte =
      (ptr_reg == `RA_PART_LO) ? PART_CODE[7:0] :
      (ptr_reg == `RA_PART_HI) ? PART_CODE[15:8] :
      (ptr_reg == `RA_REV) ? REV_CODE :
      (ptr_reg == `RA_SYSMAIN) ? {3'h0, sysmain_reg, 3'h0} :
      (ptr_reg == `RA_CLKCFG) ? clkcfg_reg :
      (ptr_reg == `RA_IRQCFG) ? {5'h00, irqcfg_reg} :
      (ptr_reg == `RA_FLAGS) ? flags_reg :
      (ptr_reg == `RA_MASK) ? mask_reg :
      (ptr_reg == `RA_PINF_LO) ? pin_flags_reg[7:0] :
      (ptr_reg == `RA_PINF_HI) ? pin_flags_reg[15:8] :
      (ptr_reg == `RA_PINE_LO) ? pin_en_reg[7:0] :
      (ptr_reg == `RA_PINE_HI) ? pin_en_reg[15:8] :
      (ptr_reg == `RA_PWMF) ? pwm_flags_reg :
      (ptr_reg == `RA_PWME) ? pwm_en_reg : 8'h00;
   // bus slave: address, pointer, auto-increment writes and reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bits_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         first_reg <= 1'b0;
         have_ptr_reg <= 1'b0;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (ce) begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         if (start_det) begin
            st_reg <= ST_RECV;
            bits_reg <= 4'h0;
            first_reg <= 1'b1;
            have_ptr_reg <= 1'b0;
            oe_reg <= 1'b0;
         end else if (stop_det) begin
            st_reg <= ST_IDLE;
            oe_reg <= 1'b0;
         end else begin
            unique case (st_reg)
               ST_IDLE: begin
               end
               ST_RECV: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_in};
                     bits_reg <= bits_reg + 4'h1;
                  end else if (byte_done) begin
                     first_reg <= 1'b0;
                     if (first_reg && !addr_hit) begin
                        st_reg <= ST_IDLE;
                     end else begin
                        st_reg <= ST_ACK;
                        oe_reg <= 1'b1;
                     end
                     if (first_reg) begin
                        rw_reg <= shift_reg[0];
                     end else if (!have_ptr_reg) begin
                        ptr_reg <= shift_reg;
                        have_ptr_reg <= 1'b1;
                     end else begin
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bits_reg <= 4'h0;
                     if (rw_reg) begin
                        st_reg <= ST_SEND;
                        shift_reg <= rd_byte;
                        oe_reg <= ~rd_byte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                     end else begin
                        st_reg <= ST_RECV;
                        oe_reg <= 1'b0;
                     end
                  end
               end
               ST_SEND: begin
                  if (scl_fall) begin
                     if (bits_reg == 4'h7) begin
                        st_reg <= ST_RACK;
                        oe_reg <= 1'b0;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        oe_reg <= ~shift_reg[6];
                        bits_reg <= bits_reg + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     nack_reg <= sda_in;
                  end else if (scl_fall) begin
                     bits_reg <= 4'h0;
                     if (nack_reg) begin
                        st_reg <= ST_IDLE;
                     end else begin
                        st_reg <= ST_SEND;
                        shift_reg <= rd_byte;
                        oe_reg <= ~rd_byte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               default: st_reg <= ST_IDLE;
            endcase
         end
      end
   end
   // write decode
   logic wr_sys, wr_clk, wr_irq, wr_flags, wr_mask;
   logic wr_pinf_lo, wr_pinf_hi, wr_pine_lo, wr_pine_hi, wr_pwmf, wr_pwme;
   assign wr_sys = wr_pulse && (ptr_reg == `RA_SYSMAIN);
   assign wr_clk = wr_pulse && (ptr_reg == `RA_CLKCFG);
   assign wr_irq = wr_pulse && (ptr_reg == `RA_IRQCFG);
   assign wr_flags = wr_pulse && (ptr_reg == `RA_FLAGS);
   assign wr_mask = wr_pulse && (ptr_reg == `RA_MASK);
   assign wr_pinf_lo = wr_pulse && (ptr_reg == `RA_PINF_LO);
   assign wr_pinf_hi = wr_pulse && (ptr_reg == `RA_PINF_HI);
   assign wr_pine_lo = wr_pulse && (ptr_reg == `RA_PINE_LO);
   assign wr_pine_hi = wr_pulse && (ptr_reg == `RA_PINE_HI);
   assign wr_pwmf = wr_pulse && (ptr_reg == `RA_PWMF);
   assign wr_pwme = wr_pulse && (ptr_reg == `RA_PWME);
   // event gathering; set wins over a clear in the same cycle
   logic wake_evt;
   logic [7:0] flag_set;
   logic [15:0] pin_clr;
   logic [7:0] flags_next, pwm_flags_next;
   logic [15:0] pin_flags_next;
   assign wake_evt = addr_hit && deep_standby_reg;
   assign pin_clr = {wr_pinf_hi ? shift_reg : 8'h00, wr_pinf_lo ? shift_reg : 8'h00};
   assign pin_flags_next = (pin_flags_reg & ~pin_clr) | events.pin_change;
   assign pwm_flags_next = (pwm_flags_reg & ~(wr_pwmf ? shift_reg : 8'h00))
      | events.pwm_done;
   assign flag_set = {
      |(events.pin_change & pin_en_reg),
      |(events.pwm_done & pwm_en_reg),
      wake_evt | events.sleep_resume,
      events.drift_alarm,
      events.cal_done,
      events.touch,
      events.ratio_unit_two_event,
      events.ratio_unit_one_event};
   assign flags_next = (flags_reg & ~(wr_flags ? shift_reg : 8'h00)) | flag_set;
   // control and status registers; soft reset returns them to reset values
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sysmain_reg <= 2'h0;
         deep_standby_reg <= 1'b0;
         soft_rst_reg <= 1'b0;
         clkcfg_reg <= `RST_CLKCFG;
         irqcfg_reg <= 3'h0;
         flags_reg <= `RST_BYTE;
         mask_reg <= `RST_BYTE;
         pin_flags_reg <= `RST_WORD;
         pin_en_reg <= `RST_WORD;
         pwm_flags_reg <= `RST_BYTE;
         pwm_en_reg <= `RST_BYTE;
      end else if (ce) begin
         soft_rst_reg <= wr_sys && shift_reg[`SYS_SOFTRST];
         if (soft_rst_reg) begin
            sysmain_reg <= 2'h0;
            deep_standby_reg <= 1'b0;
            clkcfg_reg <= `RST_CLKCFG;
            irqcfg_reg <= 3'h0;
            flags_reg <= `RST_BYTE;
            mask_reg <= `RST_BYTE;
            pin_flags_reg <= `RST_WORD;
            pin_en_reg <= `RST_WORD;
            pwm_flags_reg <= `RST_BYTE;
            pwm_en_reg <= `RST_BYTE;
         end else begin
            if (wr_sys) begin
               sysmain_reg <= {shift_reg[`SYS_SPEED], shift_reg[`SYS_SLEEP]};
            end
            if (wr_sys && shift_reg[`SYS_STANDBY]) begin
               deep_standby_reg <= 1'b1;
            end else if (wake_evt) begin
               deep_standby_reg <= 1'b0;
            end
            if (wr_clk) clkcfg_reg <= shift_reg;
            if (wr_irq) irqcfg_reg <= shift_reg[2:0];
            if (wr_mask) mask_reg <= shift_reg;
            if (wr_pine_lo) pin_en_reg[7:0] <= shift_reg;
            if (wr_pine_hi) pin_en_reg[15:8] <= shift_reg;
            if (wr_pwme) pwm_en_reg <= shift_reg;
            flags_reg <= flags_next;
            pin_flags_reg <= pin_flags_next;
            pwm_flags_reg <= pwm_flags_next;
         end
      end
   end
   // clock generation: 2 MHz engine, spread sensor clock, PWM phase step
   logic [5:0] eng_cnt_reg;
   logic [12:0] sens_cnt_reg;
   logic [7:0] lfsr_reg;
   logic [23:0] phase_reg;
   logic run, eng_tick, sens_ok, sens_run, sens_hit, pwm_run;
   logic [12:0] sdiv, sens_limit;
   logic [24:0] phase_sum;
   logic [23:0] phase_inc;
   assign run = ~deep_standby_reg;
   assign eng_tick = run && (eng_cnt_reg == 6'(`ENG_DIV - 1));
   assign sens_ok = clkcfg_reg[7:5] >= `SDIV_FIRST;
   assign sdiv = `SDIV_BASE << (clkcfg_reg[7:5] - `SDIV_FIRST);
   // divisor times 4 or 5 by a random bit averages 4.5
   assign sens_limit = (sdiv << 2) + (lfsr_reg[0] ? sdiv : 13'h0000) - 13'h0001;
   assign sens_run = sens_ok && !clkcfg_reg[`CLK_CS_OFF];
   assign sens_hit = sens_run && eng_tick && (sens_cnt_reg >= sens_limit);
   assign pwm_run = run && !clkcfg_reg[`CLK_PWM_OFF];
   assign phase_inc = 24'(`PWM_INC_BASE) << clkcfg_reg[4:3];
   assign phase_sum = {1'b0, phase_reg} + {1'b0, phase_inc};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eng_cnt_reg <= 6'h00;
         sens_cnt_reg <= 13'h0000;
         lfsr_reg <= 8'h01;
         phase_reg <= 24'h00_0000;
      end else if (ce) begin
         if (run) eng_cnt_reg <= eng_tick ? 6'h00 : eng_cnt_reg + 6'h01;
         if (sens_hit) begin
            sens_cnt_reg <= 13'h0000;
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
         end else if (sens_run && eng_tick) begin
            sens_cnt_reg <= sens_cnt_reg + 13'h0001;
         end
         if (pwm_run) phase_reg <= phase_sum[23:0];
      end
   end

   // registered control outputs toward the other modules
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_ctl <= '0;
      end else if (ce) begin
         clk_ctl.engine_tick <= eng_tick;
         clk_ctl.sensor_tick <= sens_hit;
         clk_ctl.pwm_tick <= pwm_run && phase_sum[24];
         clk_ctl.gpio_clk_en <= run && !clkcfg_reg[`CLK_GPIO_OFF];
         clk_ctl.pwm_clk_en <= pwm_run;
         clk_ctl.sense_clk_en <= run && !clkcfg_reg[`CLK_CS_OFF];
         clk_ctl.sleep_en <= sysmain_reg[0];
         clk_ctl.engine_speed_sel <= sysmain_reg[1];
         clk_ctl.deep_standby <= deep_standby_reg;
         clk_ctl.soft_reset <= soft_rst_reg;
      end
   end

   // interrupt output with polarity, type and master enable
   logic pending, pend_q, irq_act;
   logic [15:0] pulse_cnt_reg;
   assign pending = |(flags_reg & mask_reg);
   assign irq_act = irqcfg_reg[`IRQ_MASTER] &&
      (irqcfg_reg[`IRQ_TYPE] ? (pulse_cnt_reg != 16'h0000) : pending);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q <= 1'b0;
         pulse_cnt_reg <= 16'h0000;
         irq_out <= 1'b1;
      end else if (ce) begin
         pend_q <= pending;
         if (pending && !pend_q) begin
            pulse_cnt_reg <= 16'(PULSE_CYC);
         end else if (pulse_cnt_reg != 16'h0000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
         end
         irq_out <= irqcfg_reg[`IRQ_POL] ? irq_act : ~irq_act;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   sequence seq_standby_write;
      wr_sys && shift_reg[`SYS_STANDBY];
   endsequence
   sequence seq_wake;
      addr_hit && deep_standby_reg;
   endsequence

   chk_standby_reads_zero: assert property ((ptr_reg == `RA_SYSMAIN) |-> rd_byte[1:0] == 2'h0)
      else $error("standby or reset bit read as one");
   chk_standby_enter: assert property (seq_standby_write ##1 !soft_rst_reg
      |-> deep_standby_reg ##1 clk_ctl.deep_standby)
      else $error("standby not entered");
   chk_wake_resume: assert property (seq_wake |=> !deep_standby_reg && flags_reg[`FLAG_RESUME])
      else $error("wake did not set resume flag");
   chk_soft_reset: assert property (wr_sys && shift_reg[`SYS_SOFTRST]
      |=> soft_rst_reg ##1 (clkcfg_reg == `RST_CLKCFG && mask_reg == 8'h00))
      else $error("soft reset did not restore registers");
   chk_flag_set_wins: assert property (wr_flags && !soft_rst_reg && |(flag_set & shift_reg)
      |=> |(flags_reg & $past(flag_set)))
      else $error("event lost during clear");
   chk_level_irq: assert property (irqcfg_reg[`IRQ_MASTER] && !irqcfg_reg[`IRQ_TYPE] && pending
      |=> irq_out == $past(irqcfg_reg[`IRQ_POL]))
      else $error("level interrupt not active");
   chk_master_off: assert property (!irqcfg_reg[`IRQ_MASTER]
      |=> irq_out == !$past(irqcfg_reg[`IRQ_POL]))
      else $error("interrupt active while disabled");
   chk_edge_pulse: assert property (pending && !pend_q |=> pulse_cnt_reg == 16'(PULSE_CYC))
      else $error("edge pulse length wrong");
   chk_sensor_reserved: assert property (!sens_ok |=> !clk_ctl.sensor_tick)
      else $error("sensor clock runs on reserved code");
   chk_gpio_gate: assert property (clkcfg_reg[`CLK_GPIO_OFF] |=> !clk_ctl.gpio_clk_en)
      else $error("gpio clock not gated");
endmodule // system_control_and_interrupts

// ==== testbench/i2c_host_model.sv ====
`timescale 1ns/10ps
// host processor on the two-wire bus, data line pulled up
module i2c_host_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input wire logic clk,
   input wire logic sda_oe,
   output logic scl_in,
   output logic sda_in
);
   logic scl_r = 1'b1;
   logic sda_r = 1'b1;
   // wired-and of both drivers
   assign scl_in = scl_r;
   assign sda_in = sda_r & ~sda_oe;
   // each clock phase lasts four cycles
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   task automatic start();
      sda_r = 1'b1;
      half();
      scl_r = 1'b1;
      half();
      sda_r = 1'b0;
      half();
      scl_r = 1'b0;
   endtask
   task automatic stop();
      sda_r = 1'b0;
      half();
      scl_r = 1'b1;
      half();
      sda_r = 1'b1;
      half();
   endtask
   // data moves only while the clock line is low
   task automatic bit_io(input logic b, output logic s);
      sda_r = b;
      half();
      scl_r = 1'b1;
      half();
      s = sda_in;
      scl_r = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ack);
   endtask
   // pointer write, then a data byte or a restarted one-byte read ended by nack
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd,
         output logic [7:0] q, output logic ok);
      logic [7:0] dummy;
      logic a1;
      logic a2;
      logic a3;
      logic nk;
      start();
      byte_io({ADDR, 1'b0}, dummy, a1);
      byte_io(a, dummy, a2);
      if (rd) begin
         start();
         byte_io({ADDR, 1'b1}, dummy, a3);
         byte_io(8'hff, q, nk);
      end else begin
         byte_io(d, dummy, a3);
         q = 8'h00;
      end
      stop();
      ok = ~(a1 | a2 | a3);
   endtask
endmodule // i2c_host_model

// ==== testbench/tb_system_control_and_interrupts.sv ====
`timescale 1ns/10ps
module tb_system_control_and_interrupts;
   import sysctl_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
   logic clk, rst, ce, scl_in, sda_in, sda_oe, irq_out, ok, sr_seen;
   logic [7:0] q;
   event_in_t events;
   clock_ctl_t clk_ctl;
   int fail_count = 0;
   int checks = 0;
   int ne, np, ns, w;
   row_t rows[9] = '{'{8'h03, 8'h08, 8'h08}, '{8'h04, 8'h7b, 8'h7b}, '{8'h06, 8'hf9, 8'h01},
      '{8'h09, 8'ha5, 8'ha5}, '{8'h0c, 8'h34, 8'h34}, '{8'h0d, 8'h12, 8'h12},
      '{8'h0f, 8'h81, 8'h81}, '{8'h05, 8'h55, 8'h00}, '{8'h02, 8'hff, 8'h01}};
   logic [7:0] rst_exp[16] = '{8'h5a, 8'h5a, 8'h01, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   system_control_and_interrupts #(.PULSE_CYC(4)) system_control_and_interrupts_i (.clk(clk),
      .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
      .events(events), .clk_ctl(clk_ctl), .irq_out(irq_out));
   i2c_host_model i2c_host_model_i (.clk(clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
   // clock and soft reset pulse monitor
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rst) sr_seen <= 1'b0;
      else if (clk_ctl.soft_reset) sr_seen <= 1'b1;
   end
   task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp1(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i2c_host_model_i.xfer(a, d, 1'b0, q, ok);
      cmp1("write ack", 1'b1, ok);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      i2c_host_model_i.xfer(a, 8'h00, 1'b1, q, ok);
      cmp1("read ack", 1'b1, ok);
      cmp8($sformatf("reg %h", a), e, q);
   endtask
   task automatic pulse(input event_in_t v);
      events = v;
      @(negedge clk);
      events = '0;
      repeat (3) @(negedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      events = '0;
      ce = 1'b1;
      repeat (4) @(negedge clk);
      cmp1("irq in reset", 1'b1, irq_out);
      cmp8("ctl in reset", 8'h00, clk_ctl[7:0]);
      rst = 1'b0;
      for (int i = 0; i < 16; i++) rdc(8'(i), rst_exp[i]);
      // host also writes reserved bits, an unused offset and the read-only revision; they read back zero or unchanged
      for (int i = 0; i < 9; i++) begin
         wr(rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].q);
      end
      cmp1("sleep", 1'b1, clk_ctl.sleep_en);
      cmp1("gpio clk", 1'b1, clk_ctl.gpio_clk_en);
      cmp1("pwm clk", 1'b0, clk_ctl.pwm_clk_en);
      cmp1("sense clk", 1'b0, clk_ctl.sense_clk_en);
      cmp1("speed sel", 1'b0, clk_ctl.engine_speed_sel);
      // ungate sensor and pwm clocks before counting their ticks
      wr(8'h04, 8'h78);
      {ne, np, ns} = '0;
      for (int i = 0; i < 28800; i++) begin
         @(negedge clk);
         ne += clk_ctl.engine_tick;
         np += clk_ctl.pwm_tick;
         ns += clk_ctl.sensor_tick;
      end
      cmp1("engine rate", 1'b1, ne >= 575 && ne <= 577);
      cmp1("pwm rate", 1'b1, np >= 35 && np <= 38);
      cmp1("sensor rate", 1'b1, ns >= 1 && ns <= 3);
      // pins 2 and 3 change, only pin 2 enabled; pwm channel 1 done but disabled
      pulse({16'h000c, 8'h02, 6'h00});
      cmp1("irq level", 1'b0, irq_out);
      rdc(8'h0a, 8'h0c);
      rdc(8'h0e, 8'h02);
      rdc(8'h08, 8'h80);
      wr(8'h08, 8'h00);
      rdc(8'h08, 8'h80);
      wr(8'h0a, 8'h0c);
      wr(8'h0e, 8'h02);
      wr(8'h08, 8'h80);
      rdc(8'h08, 8'h00);
      cmp1("irq cleared", 1'b1, irq_out);
      // each core event sets its own flag, also for sources that the mask leaves off
      for (int i = 0; i < 6; i++) begin
         pulse(event_in_t'(30'(1 << i)));
         rdc(8'h08, 8'(1 << i));
         wr(8'h08, 8'(1 << i));
      end
      wr(8'h06, 8'h00);
      pulse({24'h0, 6'h04});
      cmp1("irq masked", 1'b1, irq_out);
      wr(8'h06, 8'h05);
      cmp1("irq high", 1'b1, irq_out);
      wr(8'h06, 8'h04);
      cmp1("irq off high", 1'b0, irq_out);
      wr(8'h08, 8'hff);
      wr(8'h06, 8'h07);
      events = {24'h0, 6'h04};
      @(negedge clk);
      events = '0;
      w = 0;
      for (int i = 0; i < 10 && !irq_out; i++) @(negedge clk);
      while (irq_out === 1'b1 && w < 20) begin
         w++;
         @(negedge clk);
      end
      cmp1("edge width", 1'b1, w == 4);
      wr(8'h08, 8'hff);
      wr(8'h03, 8'h01);
      cmp1("standby", 1'b1, clk_ctl.deep_standby);
      rdc(8'h03, 8'h00);
      cmp1("woken", 1'b0, clk_ctl.deep_standby);
      rdc(8'h08, 8'h20);
      wr(8'h03, 8'h02);
      cmp1("soft reset", 1'b1, sr_seen);
      rdc(8'h04, 8'hfe);
      rdc(8'h09, 8'h00);
      // an event while the clock enable is low is not taken
      ce = 1'b0;
      pulse({24'h0, 6'h04});
      ce = 1'b1;
      rdc(8'h08, 8'h00);
      end_sim();
   end
endmodule // tb_system_control_and_interrupts
